// file: testbench.sv
`timescale 1ns/100ps
`include "txo_cfg.svh"
module testbench;
	logic                   mclk = 1'b0;
	logic                   sys_rst = 1'b1;
	logic [7:0]             avs_address = 8'h00;
	logic                   avs_read = 1'b0;
	logic                   avs_write = 1'b0;
	logic [31:0]            avs_writedata = 32'h0;
	logic [31:0]            avs_readdata;
	logic                   avs_waitrequest;
	txo_pkg::txo_pm_req_s   pm_req;
	logic [15:0]            pm_rdata;
	txo_pkg::txo_file_req_s file_req;
	logic [7:0]             file_rdata;
	integer                 errors = 0;
	integer                 checks = 0;
	integer                 seed = 32'h81a37514;
	integer                 i;
	integer                 cyc;
	logic [20:0]            ptr;
	logic [15:0]            pw;
	logic [15:0]            nx;
	logic [11:0]            fa;
	logic [7:0]             lat, w, k8, r, f;
	logic [7:0]             hold [8];
	logic [3:0]             bank;
	logic [1:0]             m;
	logic                   z = 1'b0;
	logic                   n = 1'b0;
	logic [31:0]            q;
	realtime                t;
	// clock
	always #5 mclk = ~mclk;
	txo_core dut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pm_req(pm_req), .pm_rdata(pm_rdata),
		.file_req(file_req), .file_rdata(file_rdata));
	txo_mem_model fm (.mclk(mclk), .pm_req(pm_req), .pm_rdata(pm_rdata),
		.file_req(file_req), .file_rdata(file_rdata));
	// verdict
	task test_done;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// value compare
	task cmp(input logic [31:0] g, input logic [31:0] e, input string s);
		checks++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: %s got %h expected %h", $time, s, g, e);
		end
	endtask
	// one avalon cycle, held until waitrequest is sampled low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask
	// execute one instruction, check it is busy late and done in time
	task run(input logic [15:0] ins, input logic [15:0] nw, input integer c);
		bus(1'b1, `TXO_OFS_INSTR, {16'h0, ins});
		bus(1'b1, `TXO_OFS_NEXT, {16'h0, nw});
		bus(1'b1, `TXO_OFS_CTRL, 32'h1);
		t = $realtime;
		repeat (c - 2) @(posedge mclk);
		bus(1'b0, `TXO_OFS_STATUS, 32'h0);
		cmp(q[0], 1'b1, "still busy");
		do bus(1'b0, `TXO_OFS_STATUS, 32'h0);
		while (q[0] !== 1'b0 && $realtime - t < 500);
		cmp(($realtime - t) <= 10 * (c + 4), 1'b1, "op length");
	endtask
	// model of the byte seen by a table read at pointer p
	function automatic logic [7:0] pmb(input logic [20:0] p);
		logic [15:0] v;
		v = p[16:1] ^ 16'hC35A;
		return p[0] ? v[15:8] : v[7:0];
	endfunction
	// hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		$display("Error at %0t: watchdog expired", $time);
		test_done;
	end
	initial begin
		foreach (hold[j]) hold[j] = 8'hFF;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		bus(1'b0, `TXO_OFS_HOLD_LO, 32'h0);
		cmp(q, 32'hFFFFFFFF, "hold lo reset");
		bus(1'b0, 8'h30, 32'h0);
		cmp(q, 32'h0, "unmapped");
		$display("reset test done");
		// table reads in every mode, with both wrap points
		for (i = 0; i < 8; i++) begin
			m = i[1:0];
			ptr = (i == 2) ? 21'h0 : (i == 7) ? 21'h1FFFFF : 21'($random(seed));
			bus(1'b1, `TXO_OFS_PTR, {11'h0, ptr});
			run({14'h2, m}, 16'h0, 8);
			if (m == 2'h3) ptr = ptr + 1'b1;
			lat = pmb(ptr);
			if (m == 2'h1) ptr = ptr + 1'b1;
			if (m == 2'h2) ptr = ptr - 1'b1;
			bus(1'b0, `TXO_OFS_LATCH, 32'h0);
			cmp(q, {24'h0, lat}, "latch");
			bus(1'b0, `TXO_OFS_PTR, 32'h0);
			cmp(q, {11'h0, ptr}, "rd ptr");
		end
		$display("table read test done");
		// table writes to slots 0-2 and 4-6 (3 and 7 are never written), latch loaded by a plain read
		for (i = 0; i < 8; i++) begin
			m = i[1:0];
			ptr = {18'($random(seed)), i[2:0]};
			bus(1'b1, `TXO_OFS_PTR, {11'h0, ptr});
			run(16'h0008, 16'h0, 8);
			lat = pmb(ptr);
			run({14'h3, m}, 16'h0, 8);
			if (m == 2'h3) ptr = ptr + 1'b1;
			hold[ptr[2:0]] = lat;
			if (m == 2'h1) ptr = ptr + 1'b1;
			if (m == 2'h2) ptr = ptr - 1'b1;
			bus(1'b0, `TXO_OFS_HOLD_LO, 32'h0);
			cmp(q, {hold[3], hold[2], hold[1], hold[0]}, "hold lo");
			bus(1'b0, `TXO_OFS_HOLD_HI, 32'h0);
			cmp(q, {hold[7], hold[6], hold[5], hold[4]}, "hold hi");
			bus(1'b0, `TXO_OFS_PTR, 32'h0);
			cmp(q, {11'h0, ptr}, "wr ptr");
		end
		$display("table write test done");
		// xor with literal, then with file in both destinations and banks
		for (i = 0; i < 8; i++) begin
			w = 8'($random(seed));
			k8 = (i == 0 || i == 3) ? w : 8'($random(seed));
			f = 8'($random(seed));
			bank = 4'($random(seed));
			bus(1'b1, `TXO_OFS_W, {24'h0, w});
			bus(1'b1, `TXO_OFS_BANK, {28'h0, bank});
			fa = i[1] ? {bank, f} : {{4{f[7]}}, f};
			r = w ^ k8;
			if (i < 3) begin
				run({8'h0A, k8}, 16'h0, 4);
				w = r;
			end else begin
				fm.mem[fa] = k8;
				run({6'h06, i[0], i[1], f}, 16'h0, 4);
				if (!i[0]) w = r;
				cmp(fm.mem[fa], i[0] ? r : k8, "file dest");
			end
			z = (r == 8'h00);
			n = r[7];
			bus(1'b0, `TXO_OFS_W, 32'h0);
			cmp(q, {24'h0, w}, "w");
			bus(1'b0, `TXO_OFS_STATUS, 32'h0);
			cmp({q[4], q[2]}, {n, z}, "nz");
		end
		$display("xor test done");
		// test and skip over one and two word followers
		for (i = 0; i < 8; i++) begin
			f = 8'($random(seed));
			bank = 4'($random(seed));
			bus(1'b1, `TXO_OFS_BANK, {28'h0, bank});
			fa = i[0] ? {bank, f} : {{4{f[7]}}, f};
			k8 = (i < 4) ? 8'h00 : 8'($random(seed)) | 8'h01;
			fm.mem[fa] = k8;
			nx = i[1] ? (i[0] ? 16'h7712 : 16'hC123) : 16'h0F00;
			cyc = (k8 != 8'h00) ? 4 : (i[1] ? 12 : 8);
			run({7'h33, i[0], f}, nx, cyc);
			bus(1'b0, `TXO_OFS_STATUS, 32'h0);
			cmp({q[4], q[2], q[1]}, {n, z, k8 == 8'h00}, "skip");
		end
		$display("skip test done");
		test_done;
	end
endmodule

// file: txo_cfg.svh
`ifndef TXO_CFG_SVH
`define TXO_CFG_SVH
// register offsets (byte addresses, one word each)
`define TXO_OFS_CTRL      8'h00
`define TXO_OFS_INSTR     8'h04
`define TXO_OFS_W         8'h08
`define TXO_OFS_STATUS    8'h0C
`define TXO_OFS_PTR       8'h10
`define TXO_OFS_LATCH     8'h14
`define TXO_OFS_BANK      8'h18
`define TXO_OFS_NEXT      8'h1C
`define TXO_OFS_HOLD_LO   8'h20
`define TXO_OFS_HOLD_HI   8'h24
// status bit positions
`define TXO_ST_BUSY       0
`define TXO_ST_SKIP       1
`define TXO_ST_ZERO       2
`define TXO_ST_NEG        4
// instruction encodings
`define TXO_ENC_TBL       14'h0002
`define TXO_ENC_TSTFZ     7'h33
`define TXO_ENC_XORLIT    8'h0A
`define TXO_ENC_XORFILE   6'h06
// pointer modes
`define TXO_MODE_NONE     2'h0
`define TXO_MODE_POSTINC  2'h1
`define TXO_MODE_POSTDEC  2'h2
`define TXO_MODE_PREINC   2'h3
// phases per instruction cycle
`define TXO_PHASES        4
`endif

// file: txo_core.sv
// How it works
// - table read mode: none, post inc/dec, pre-inc
// - table read copies memory byte into latch
// - pointer is 21 bits, byte addressing
// - pointer bit 0 selects low/high byte
// - read updates pointer per mode field
// - table write mode field, same four codes
// - write stores latch into holding slot ptr[2:0]
// - holding registers only stage, memory unchanged
// - test-skip reads file, flags untouched
// - zero operand skips next, two cycles
// - skipped two-word instruction costs three cycles
// - access bit 0 uses access bank
// - xor literal into working register
// - xor updates only negative and zero
// - xor file: d selects destination
// - phases: decode, read, process, write
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "txo_cfg.svh"
module txo_core #(
	parameter int PTR_W  = 21,
	parameter int HOLD_N = 8
) (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 sys_rst,
	// avalon-mm slave
	input  wire logic [7:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	// program memory
	output txo_pkg::txo_pm_req_s      pm_req,
	input  wire logic [15:0]          pm_rdata,
	// data file
	output txo_pkg::txo_file_req_s    file_req,
	input  wire logic [7:0]           file_rdata
);
	// ========================================
	// state
	logic [15:0]           instr_ff;
	logic [15:0]           next_word_ff;
	logic [7:0]            w_ff;
	logic                  neg_ff, zero_ff, skip_ff;
	logic [PTR_W-1:0]      ptr_ff;
	logic [7:0]            latch_ff;
	logic [7:0]            fetch_ff;
	logic [3:0]            bank_ff;
	logic [7:0]            hold_ff [HOLD_N];
	logic                  busy_ff;
	logic [1:0]            phase_ff;
	logic [1:0]            cyc_ff;
	logic [1:0]            ncyc_ff;
	logic [7:0]            opnd_ff;
	logic [7:0]            res_ff;
	logic                  rd_wait_ff;
	logic [31:0]           rdata_ff;
	txo_pkg::txo_op_e      op;

	// ========================================
	// decode, shared by start and execute
	function automatic txo_pkg::txo_op_e decode(input logic [15:0] iw);
		if (iw[15:4] == 12'h000 && iw[3:2] == 2'h2)
			return txo_pkg::TXO_TBL_RD;
		if (iw[15:4] == 12'h000 && iw[3:2] == 2'h3)
			return txo_pkg::TXO_TBL_WR;
		if (iw[15:9] == `TXO_ENC_TSTFZ)
			return txo_pkg::TXO_TST_SKIP;
		if (iw[15:8] == `TXO_ENC_XORLIT)
			return txo_pkg::TXO_XOR_LIT;
		if (iw[15:10] == `TXO_ENC_XORFILE)
			return txo_pkg::TXO_XOR_FILE;
		return txo_pkg::TXO_NOP;
	endfunction

	// two-word instructions in this core: top nibble C, 0x76xx/0x77xx, 0xECxx
	function automatic logic two_word(input logic [15:0] iw);
		return (iw[15:12] == 4'hC) || (iw[15:9] == 7'h3B) || (iw[15:8] == 8'hEC);
	endfunction

	assign op = decode(instr_ff);

	// ========================================
	// bus slave: one wait cycle on read, none on write while idle; writes wait while busy
	wire bus_sel_wr = avs_write && !busy_ff;
	assign avs_waitrequest = (avs_read && !rd_wait_ff) || (avs_write && busy_ff);
	assign avs_readdata    = rdata_ff;

	// read data capture
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_wait_ff <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
		end else begin
			rd_wait_ff <= avs_read && !rd_wait_ff;
			if (avs_read && !rd_wait_ff) begin
				unique case (avs_address)
				`TXO_OFS_CTRL:    rdata_ff <= {31'h0, busy_ff};
				`TXO_OFS_INSTR:   rdata_ff <= {16'h0, instr_ff};
				`TXO_OFS_W:       rdata_ff <= {24'h0, w_ff};
				`TXO_OFS_STATUS:  rdata_ff <= {27'h0, neg_ff, 1'b0, zero_ff, skip_ff, busy_ff};
				`TXO_OFS_PTR:     rdata_ff <= {{(32-PTR_W){1'b0}}, ptr_ff};
				`TXO_OFS_LATCH:   rdata_ff <= {24'h0, latch_ff};
				`TXO_OFS_BANK:    rdata_ff <= {28'h0, bank_ff};
				`TXO_OFS_NEXT:    rdata_ff <= {16'h0, next_word_ff};
				`TXO_OFS_HOLD_LO: rdata_ff <= {hold_ff[3], hold_ff[2], hold_ff[1], hold_ff[0]};
				`TXO_OFS_HOLD_HI: rdata_ff <= {hold_ff[7], hold_ff[6], hold_ff[5], hold_ff[4]};
				default:          rdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ========================================
	// sequencer: writing ctrl bit 0 starts the loaded instruction
	wire start = bus_sel_wr && avs_address == `TXO_OFS_CTRL && avs_byteenable[0]
		&& avs_writedata[0];
	wire last_q = phase_ff == 2'(`TXO_PHASES - 1);
	wire done   = busy_ff && last_q && cyc_ff == ncyc_ff;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_ff  <= 1'b0;
			phase_ff <= 2'h0;
			cyc_ff   <= 2'h0;
		end else if (start) begin
			busy_ff  <= 1'b1;
			phase_ff <= 2'h0;
			cyc_ff   <= 2'h0;
		end else if (busy_ff) begin
			phase_ff <= phase_ff + 2'h1;
			if (last_q)
				cyc_ff <= cyc_ff + 2'h1;
			if (done)
				busy_ff <= 1'b0;
		end
	end

	// cycle count: tables take 2, skip takes 1, or 2 or 3 on a zero operand
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			ncyc_ff <= 2'h0;
		else if (busy_ff && phase_ff == 2'h0 && cyc_ff == 2'h0) begin
			unique case (op)
			txo_pkg::TXO_TBL_RD, txo_pkg::TXO_TBL_WR: ncyc_ff <= 2'h1;
			default: ncyc_ff <= 2'h0;
			endcase
		end else if (busy_ff && op == txo_pkg::TXO_TST_SKIP && cyc_ff == 2'h0
			&& phase_ff == 2'h2 && opnd_ff == 8'h00)
			ncyc_ff <= two_word(next_word_ff) ? 2'h2 : 2'h1;
	end

	// ========================================
	// operand address: access bank or banked
	wire [11:0] faddr = instr_ff[8] ? {bank_ff, instr_ff[7:0]}
		: {{4{instr_ff[7]}}, instr_ff[7:0]};
	wire [1:0]  mode  = instr_ff[1:0];
	wire        is_tbl = op == txo_pkg::TXO_TBL_RD || op == txo_pkg::TXO_TBL_WR;
	wire [PTR_W-1:0] ptr_inc = ptr_ff + PTR_W'(1);
	wire [PTR_W-1:0] ptr_dec = ptr_ff - PTR_W'(1);

	// file port: read in q2, write in q4 of first cycle
	always_comb begin
		file_req       = '0;
		file_req.addr  = faddr;
		file_req.rd    = busy_ff && cyc_ff == 2'h0 && phase_ff == 2'h1
			&& (op == txo_pkg::TXO_TST_SKIP || op == txo_pkg::TXO_XOR_FILE);
		file_req.wr    = busy_ff && cyc_ff == 2'h0 && last_q
			&& op == txo_pkg::TXO_XOR_FILE && instr_ff[9];
		file_req.wdata = res_ff;
	end

	// program memory fetch in q2 of second cycle
	always_comb begin
		pm_req      = '0;
		pm_req.req  = busy_ff && op == txo_pkg::TXO_TBL_RD && cyc_ff == 2'h1
			&& phase_ff == 2'h1;
		pm_req.addr = {ptr_ff[PTR_W-1:1], 1'b0};
	end

	// operand capture and processing
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			opnd_ff <= 8'h00;
			res_ff  <= 8'h00;
		end else if (busy_ff && cyc_ff == 2'h0) begin
			if (phase_ff == 2'h1)
				opnd_ff <= op == txo_pkg::TXO_XOR_LIT ? instr_ff[7:0] : file_rdata;
			if (phase_ff == 2'h2)
				res_ff <= w_ff ^ opnd_ff;
		end
	end

	// working register and flags written in q4
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			w_ff    <= 8'h00;
			neg_ff  <= 1'b0;
			zero_ff <= 1'b0;
		end else if (bus_sel_wr && avs_address == `TXO_OFS_W && avs_byteenable[0]) begin
			w_ff <= avs_writedata[7:0];
		end else if (busy_ff && cyc_ff == 2'h0 && last_q
			&& (op == txo_pkg::TXO_XOR_LIT || op == txo_pkg::TXO_XOR_FILE)) begin
			if (op == txo_pkg::TXO_XOR_LIT || !instr_ff[9])
				w_ff <= res_ff;
			neg_ff  <= res_ff[7];
			zero_ff <= res_ff == 8'h00;
		end
	end

	// skip flag, held until next start
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			skip_ff <= 1'b0;
		else if (start)
			skip_ff <= 1'b0;
		else if (busy_ff && op == txo_pkg::TXO_TST_SKIP && cyc_ff == 2'h0
			&& phase_ff == 2'h2)
			skip_ff <= opnd_ff == 8'h00;
	end

	// table pointer: pre-inc in first q4, post-update at end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			ptr_ff <= '0;
		else if (bus_sel_wr && avs_address == `TXO_OFS_PTR)
			ptr_ff <= avs_writedata[PTR_W-1:0];
		else if (busy_ff && is_tbl && last_q) begin
			if (cyc_ff == 2'h0 && mode == `TXO_MODE_PREINC)
				ptr_ff <= ptr_inc;
			else if (cyc_ff == 2'h1 && mode == `TXO_MODE_POSTINC)
				ptr_ff <= ptr_inc;
			else if (cyc_ff == 2'h1 && mode == `TXO_MODE_POSTDEC)
				ptr_ff <= ptr_dec;
		end
	end

	// fetched byte held from q2 until the latch write in q4
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			fetch_ff <= 8'h00;
		else if (pm_req.req)
			fetch_ff <= ptr_ff[0] ? pm_rdata[15:8] : pm_rdata[7:0];
	end

	// table latch: read lands in final q4
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			latch_ff <= 8'h00;
		else if (bus_sel_wr && avs_address == `TXO_OFS_LATCH && avs_byteenable[0])
			latch_ff <= avs_writedata[7:0];
		else if (busy_ff && op == txo_pkg::TXO_TBL_RD && cyc_ff == 2'h1 && last_q)
			latch_ff <= fetch_ff;
	end

	// holding registers, staging only; program memory is never written
	generate
		for (genvar i = 0; i < HOLD_N; i++) begin : g_hold
			always_ff @(posedge mclk or posedge sys_rst) begin
				if (sys_rst)
					hold_ff[i] <= 8'hFF;
				else if (busy_ff && op == txo_pkg::TXO_TBL_WR && cyc_ff == 2'h1 && last_q
					&& ptr_ff[2:0] == 3'(i))
					hold_ff[i] <= latch_ff;
			end
		end
	endgenerate

	// instruction, next word and bank loaded by software
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			instr_ff     <= 16'h0000;
			next_word_ff <= 16'h0000;
			bank_ff      <= 4'h0;
		end else if (bus_sel_wr) begin
			if (avs_address == `TXO_OFS_INSTR)
				instr_ff <= avs_writedata[15:0];
			if (avs_address == `TXO_OFS_NEXT)
				next_word_ff <= avs_writedata[15:0];
			if (avs_address == `TXO_OFS_BANK)
				bank_ff <= avs_writedata[3:0];
		end
	end

	// ========================================
	// checks
	chk_tbl_two_cycles: assert property (@(posedge mclk) disable iff (sys_rst)
		start && (avs_writedata[0]) && decode(instr_ff) == txo_pkg::TXO_TBL_RD
		|-> ##8 busy_ff ##1 !busy_ff)
		else $error("table read not two cycles");
	chk_latch_final_q: assert property (@(posedge mclk) disable iff (sys_rst)
		busy_ff && op == txo_pkg::TXO_TBL_RD && !(cyc_ff == 2'h1 && last_q)
		|=> $stable(latch_ff))
		else $error("table latch written before final phase");
	chk_xor_lit_res: assert property (@(posedge mclk) disable iff (sys_rst)
		start && decode(instr_ff) == txo_pkg::TXO_XOR_LIT
		|-> ##5 w_ff == ($past(w_ff, 5) ^ $past(instr_ff[7:0], 5)))
		else $error("xor literal result wrong");
	chk_xor_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		start && decode(instr_ff) == txo_pkg::TXO_XOR_LIT
		|-> ##5 zero_ff == (w_ff == 8'h00) && neg_ff == w_ff[7])
		else $error("xor flags wrong");
	chk_skip_flags: assert property (@(posedge mclk) disable iff (sys_rst)
		busy_ff && op == txo_pkg::TXO_TST_SKIP
		|=> $stable(w_ff) && $stable(zero_ff) && $stable(neg_ff))
		else $error("test skip touched flags");
	chk_postinc_ptr: assert property (@(posedge mclk) disable iff (sys_rst)
		start && decode(instr_ff) == txo_pkg::TXO_TBL_RD && instr_ff[1:0] == 2'h1
		|-> ##9 ptr_ff == $past(ptr_ff, 9) + PTR_W'(1))
		else $error("post increment wrong");
	chk_preinc_fetch: assert property (@(posedge mclk) disable iff (sys_rst)
		start && decode(instr_ff) == txo_pkg::TXO_TBL_RD && instr_ff[1:0] == 2'h3
		|-> ##6 pm_req.req && ptr_ff == $past(ptr_ff, 6) + PTR_W'(1))
		else $error("pre increment fetch wrong");
	chk_file_wr_q4: assert property (@(posedge mclk) disable iff (sys_rst)
		file_req.wr |-> phase_ff == 2'h3 && instr_ff[9] && op == txo_pkg::TXO_XOR_FILE)
		else $error("file write outside q4");
	chk_hold_write: assert property (@(posedge mclk) disable iff (sys_rst)
		busy_ff && op == txo_pkg::TXO_TBL_WR && cyc_ff == 2'h1 && last_q
		|=> hold_ff[$past(ptr_ff[2:0])] == $past(latch_ff))
		else $error("holding register not written");
endmodule

// file: txo_mem_model.sv
`timescale 1ns/100ps
// program memory and data file facing the core
module txo_mem_model (
	// clock
	input  wire logic                   mclk,
	// program memory side
	input  wire txo_pkg::txo_pm_req_s   pm_req,
	output logic [15:0]                 pm_rdata,
	// data file side
	input  wire txo_pkg::txo_file_req_s file_req,
	output logic [7:0]                  file_rdata
);
	logic [7:0]  mem [4096];
	logic [15:0] pm_last = 16'h0000;
	logic [7:0]  fl_last = 8'h00;
	// nonzero fill so a read from a wrong address never looks like zero
	initial foreach (mem[j]) mem[j] = 8'h5A;
	// words follow their address; released lines show the inverse of the last value
	always_comb pm_rdata = pm_req.req ? (pm_req.addr[16:1] ^ 16'hC35A) : ~pm_last;
	always_comb file_rdata = file_req.rd ? mem[file_req.addr] : ~fl_last;
	// store file writes, remember driven values
	always @(posedge mclk) begin
		if (pm_req.req) pm_last <= pm_rdata;
		if (file_req.rd) fl_last <= file_rdata;
		if (file_req.wr) mem[file_req.addr] <= file_req.wdata;
	end
endmodule

// file: txo_pkg.sv
package txo_pkg;
	typedef enum logic [2:0] {
		TXO_NOP,
		TXO_TBL_RD,
		TXO_TBL_WR,
		TXO_TST_SKIP,
		TXO_XOR_LIT,
		TXO_XOR_FILE
	} txo_op_e;

	// program memory fetch request
	typedef struct packed {
		logic        req;
		logic [20:0] addr;
	} txo_pm_req_s;

	// data file access request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} txo_file_req_s;
endpackage
